//--- rtl/lso_limit_switch.sv
`timescale 1ns/1ps
module lso_limit_switch
	import lso_pkg::*;
#(
	parameter logic [lso_pkg::TIMER_WIDTH-1:0] STEP_CYCLES = lso_pkg::STEP_CYCLES_DEFAULT
) (
	// Clock and reset
	input  wire logic                                   i_core_clk,
	input  wire logic                                   i_reset_n,
	// Configuration
	input  wire lso_pkg::lso_func_type                  i_function,
	input  wire logic                                   i_limit_assigned,
	input  wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_on_value,
	input  wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_off_value,
	input  wire logic        [lso_pkg::DELAY_WIDTH-1:0] i_on_delay,
	input  wire logic        [lso_pkg::DELAY_WIDTH-1:0] i_off_delay,
	input  wire lso_pkg::lso_fail_type                  i_failure_mode,
	input  wire logic                                   i_invert,
	// Process inputs
	input  wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_measured,
	input  wire logic                                   i_alarm,
	input  wire logic                                   i_diag_event,
	input  wire logic                                   i_block_state,
	// Switch contact and status
	output logic                                        o_switch_closed,
	output logic                                        o_switch_status
);
	import lso_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Alarm, diagnostic and block inputs come from outside this clock.
	// The two cycles of latency are negligible against the shortest delay step.
	logic [2:0] sync_meta;
	logic [2:0] sync_out;
	wire  alarm_s = sync_out[0];
	wire  diag_s  = sync_out[1];
	wire  block_s = sync_out[2];

	// Two stages; the first is read only by the second.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_meta <= 3'h0;
			sync_out  <= 3'h0;
		end else begin
			sync_meta <= {i_block_state, i_diag_event, i_alarm};
			sync_out  <= sync_meta;
		end
	end

	// ----------------------------------------------------------------
	// Hysteresis comparator
	// ----------------------------------------------------------------
	// Clamp a delay setting to its documented range of 100.0 s.
	function automatic logic [DELAY_WIDTH-1:0] clamp_delay(input logic [DELAY_WIDTH-1:0] d);
		clamp_delay = (d > DELAY_MAX) ? DELAY_MAX : d;
	endfunction

	// Direction and hysteresis both follow from the two thresholds.
	// Comparisons are strict, so a value exactly at a threshold leaves the state alone.
	// threshold direction
	wire on_above_off = (i_on_value > i_off_value);
	wire want_close_lo = !on_above_off && (i_measured < i_on_value);
	wire want_open_lo  = !on_above_off && (i_measured > i_off_value);
	wire want_close_hi = on_above_off && (i_measured > i_on_value);
	wire want_open_hi  = on_above_off && (i_measured < i_off_value);
	// With equal thresholds both may not hold at once, so closing and opening stay exclusive.
	wire want_close = want_close_lo || want_close_hi;
	wire want_open  = (want_open_lo || want_open_hi) && !want_close;

	// Delays apply only with limit mode and a monitored variable.
	// delay gating
	wire delays_on = (i_function == FUNC_LIMIT) && i_limit_assigned;
	wire [DELAY_WIDTH-1:0] on_steps  = delays_on ? clamp_delay(i_on_delay) : DELAY_RESET;
	wire [DELAY_WIDTH-1:0] off_steps = delays_on ? clamp_delay(i_off_delay) : DELAY_RESET;

	// ----------------------------------------------------------------
	// Delay state machine
	// ----------------------------------------------------------------
	// The comparator keeps its own state so that leaving limit mode can clear it.
	lso_state_type state;
	lso_state_type next_state;
	logic          limit_closed;
	logic          next_limit_closed;
	logic          timer_run;
	logic          timer_done;
	logic [DELAY_WIDTH-1:0] timer_steps;

	// The timer runs only while a transition waits; its length follows that direction.
	assign timer_run   = (state != ST_STABLE);
	assign timer_steps = (state == ST_WAIT_CLOSE) ? on_steps : off_steps;

	// ----------------------------------------------------------------
	// Delay timer
	// ----------------------------------------------------------------
	// One timer serves both directions, since only one transition can wait at a time.
	lso_delay_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_timer (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_run      (timer_run),
		.i_steps    (timer_steps),
		.o_done     (timer_done)
	);

	// A wait is abandoned if its condition lapses before the delay has run out.
	// Leaving a wait always passes through the stable state, which restarts the timer.
	always_comb begin
		next_state        = state;
		next_limit_closed = limit_closed;
		unique case (state)
			ST_STABLE: begin
				if (!limit_closed && want_close) begin
					next_state = ST_WAIT_CLOSE;
				end else if (limit_closed && want_open) begin
					next_state = ST_WAIT_OPEN;
				end
			end
			ST_WAIT_CLOSE: begin
				if (!want_close) begin
					next_state = ST_STABLE;
				end else if (timer_done) begin
					next_limit_closed = 1'b1;
					next_state        = ST_STABLE;
				end
			end
			ST_WAIT_OPEN: begin
				if (!want_open) begin
					next_state = ST_STABLE;
				end else if (timer_done) begin
					next_limit_closed = 1'b0;
					next_state        = ST_STABLE;
				end
			end
			default: begin
				next_state = ST_STABLE;
			end
		endcase
	end

	// Comparator state is only advanced in limit mode; otherwise it rests open.
	// A return to limit mode therefore starts from open with no wait pending.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state        <= ST_STABLE;
			limit_closed <= 1'b0;
		end else if (i_function != FUNC_LIMIT) begin
			state        <= ST_STABLE;
			limit_closed <= 1'b0;
		end else begin
			state        <= next_state;
			limit_closed <= next_limit_closed;
		end
	end

	// ----------------------------------------------------------------
	// Output selection
	// ----------------------------------------------------------------
	logic normal_closed;
	logic alarm_closed;
	logic final_closed;

	// The selected function gives the contact state before any alarm or inversion.
	// function select
	always_comb begin
		unique case (i_function)
			FUNC_OPEN:   normal_closed = 1'b0;
			FUNC_CLOSED: normal_closed = 1'b1;
			FUNC_DIAG:   normal_closed = !diag_s;  // Opens on a diagnostic event.
			FUNC_LIMIT:  normal_closed = limit_closed;
			FUNC_BLOCK:  normal_closed = block_s;
			default:     normal_closed = 1'b0;     // Unused codes rest open for safety.
		endcase
	end

	// During an alarm the failure setting may replace the normal state.
	// alarm override
	always_comb begin
		unique case (i_failure_mode)
			FAIL_ACTUAL: alarm_closed = normal_closed;
			FAIL_OPEN:   alarm_closed = 1'b0;
			FAIL_CLOSED: alarm_closed = 1'b1;
			default:     alarm_closed = 1'b0;
		endcase
	end

	// Inversion comes last, so it also swaps a state forced by the alarm setting.
	// output inversion
	assign final_closed = (alarm_s ? alarm_closed : normal_closed) ^ i_invert;

	// ----------------------------------------------------------------
	// Output register
	// ----------------------------------------------------------------
	// Contact and status are registered from the same value so software never sees a stale state.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_switch_closed <= 1'b0;
			o_switch_status <= 1'b0;
		end else begin
			o_switch_closed <= final_closed;
			o_switch_status <= final_closed;
		end
	end

endmodule

//--- rtl/lso_pkg.sv
package lso_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int VALUE_WIDTH = 32;
	localparam int DELAY_WIDTH = 10;
	localparam int TIMER_WIDTH = 32;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	// Core clock period in nanoseconds.
	localparam longint CLK_PERIOD_NS = 50;
	// One delay step is a tenth of a second.
	localparam longint DELAY_STEP_NS = 100000000;
	// Cycles in one delay step, derived from the step and the clock period.
	localparam longint STEP_CYCLES_CALC = DELAY_STEP_NS / CLK_PERIOD_NS;
	localparam int STEP_CYCLES_DEFAULT = 32'(STEP_CYCLES_CALC);
	// Largest delay setting, 100.0 s in tenths.
	localparam logic [DELAY_WIDTH-1:0] DELAY_MAX = 10'h3e8;
	localparam logic [DELAY_WIDTH-1:0] DELAY_RESET = 10'h000;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [VALUE_WIDTH-1:0] THRESHOLD_RESET = 32'h0000_0000;
	localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = 32'h0000_0000;
	localparam logic [TIMER_WIDTH-1:0] TIMER_ONE = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		FUNC_OPEN    = 3'h0,
		FUNC_CLOSED  = 3'h1,
		FUNC_DIAG    = 3'h2,
		FUNC_LIMIT   = 3'h3,
		FUNC_BLOCK   = 3'h4
	} lso_func_type;

	typedef enum logic [1:0] {
		FAIL_ACTUAL  = 2'h0,
		FAIL_OPEN    = 2'h1,
		FAIL_CLOSED  = 2'h2
	} lso_fail_type;

	localparam lso_func_type FUNC_RESET = FUNC_OPEN;
	localparam lso_fail_type FAIL_RESET = FAIL_OPEN;

	// Delay state machine, one-hot.
	typedef enum logic [2:0] {
		ST_STABLE     = 3'b001,
		ST_WAIT_CLOSE = 3'b010,
		ST_WAIT_OPEN  = 3'b100
	} lso_state_type;

endpackage

//--- rtl/lso_delay_timer.sv
`timescale 1ns/1ps
module lso_delay_timer
	import lso_pkg::*;
#(
	parameter logic [lso_pkg::TIMER_WIDTH-1:0] STEP_CYCLES = lso_pkg::STEP_CYCLES_DEFAULT
) (
	// Clock and reset
	input  wire logic                            i_core_clk,
	input  wire logic                            i_reset_n,
	// Control
	input  wire logic                            i_run,
	input  wire logic [lso_pkg::DELAY_WIDTH-1:0] i_steps,
	// Status
	output logic                                 o_done
);
	import lso_pkg::*;

	logic [TIMER_WIDTH-1:0] cycle_count;
	logic [DELAY_WIDTH-1:0] step_count;
	wire                    step_end = (cycle_count == STEP_CYCLES - TIMER_ONE);

	// Done once the requested number of whole steps has passed.
	assign o_done = i_run && (step_count >= i_steps);

	// Counters restart whenever the run request drops, so each wait is timed from its start.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cycle_count <= TIMER_ZERO;
			step_count  <= DELAY_RESET;
		end else if (!i_run) begin
			cycle_count <= TIMER_ZERO;
			step_count  <= DELAY_RESET;
		end else if (step_count < i_steps) begin
			cycle_count <= step_end ? TIMER_ZERO : cycle_count + TIMER_ONE;
			if (step_end) begin
				step_count <= step_count + 10'h001;
			end
		end
	end

endmodule

//--- bench/lso_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Contact checks for the limit switch output
// ----------------------------------------------------------------
module lso_checker
	import lso_pkg::*;
#(
	parameter logic [lso_pkg::TIMER_WIDTH-1:0] STEP_CYCLES = lso_pkg::STEP_CYCLES_DEFAULT
) (
	// Clock and reset
	input wire logic                                   i_core_clk,
	input wire logic                                   i_reset_n,
	// Configuration and process inputs
	input wire lso_pkg::lso_func_type                  i_function,
	input wire logic                                   i_limit_assigned,
	input wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_on_value,
	input wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_off_value,
	input wire logic        [lso_pkg::DELAY_WIDTH-1:0] i_on_delay,
	input wire logic        [lso_pkg::DELAY_WIDTH-1:0] i_off_delay,
	input wire lso_pkg::lso_fail_type                  i_failure_mode,
	input wire logic                                   i_invert,
	input wire logic signed [lso_pkg::VALUE_WIDTH-1:0] i_measured,
	input wire logic                                   i_alarm,
	input wire logic                                   i_diag_event,
	input wire logic                                   i_block_state,
	// Contact and status
	input wire logic                                   o_switch_closed,
	input wire logic                                   o_switch_status
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	// Limit conditions; equal thresholds take the close-below direction.
	wire on_low  = i_on_value <= i_off_value;
	wire lim_ok  = i_function == FUNC_LIMIT && !i_alarm && !i_invert;
	wire go_cls  = lim_ok && (i_on_delay == 10'h000 || !i_limit_assigned)
		&& (on_low ? i_measured < i_on_value : i_measured > i_on_value);
	wire go_opn  = lim_ok && (i_off_delay == 10'h000 || !i_limit_assigned)
		&& (on_low ? i_measured > i_off_value : i_measured < i_off_value);
	wire in_band = lim_ok && (on_low ? (i_measured >= i_on_value && i_measured <= i_off_value)
		: (i_measured <= i_on_value && i_measured >= i_off_value));

	// Four held cycles cover two synchroniser flops or two state-machine steps, and the output flop.
	sequence close_held;
		go_cls [*4];
	endsequence
	sequence open_held;
		go_opn [*4];
	endsequence
	sequence alarm_held;
		(i_alarm && !i_invert) [*4];
	endsequence

	chk_status_mirror: assert property (o_switch_status == o_switch_closed)
		else $error("switch status differs from contact");
	chk_fixed_open: assert property ((i_function == FUNC_OPEN && !i_invert
		&& i_failure_mode != FAIL_CLOSED) |=> !o_switch_closed) else $error("open mode closed");
	chk_fixed_closed: assert property ((i_function == FUNC_CLOSED && !i_invert
		&& i_failure_mode == FAIL_ACTUAL) |=> o_switch_closed) else $error("closed mode open");
	chk_invert_swap: assert property ((i_function == FUNC_OPEN && i_invert
		&& i_failure_mode != FAIL_CLOSED) |=> o_switch_closed) else $error("invert ignored");
	chk_alarm_closed: assert property (alarm_held ##0 i_failure_mode == FAIL_CLOSED
		|=> o_switch_closed) else $error("alarm did not force closed");
	chk_alarm_open: assert property (alarm_held ##0 i_failure_mode == FAIL_OPEN
		|=> !o_switch_closed) else $error("alarm did not force open");
	chk_limit_close: assert property (close_held |=> o_switch_closed)
		else $error("limit close missed");
	chk_limit_open: assert property (open_held |=> !o_switch_closed)
		else $error("limit open missed");
	chk_band_hold: assert property (in_band [*5] |=> $stable(o_switch_closed))
		else $error("state changed between thresholds");
endmodule

bind lso_limit_switch lso_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
	.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_function(i_function),
	.i_limit_assigned(i_limit_assigned), .i_on_value(i_on_value), .i_off_value(i_off_value),
	.i_on_delay(i_on_delay), .i_off_delay(i_off_delay), .i_failure_mode(i_failure_mode),
	.i_invert(i_invert), .i_measured(i_measured), .i_alarm(i_alarm),
	.i_diag_event(i_diag_event), .i_block_state(i_block_state),
	.o_switch_closed(o_switch_closed), .o_switch_status(o_switch_status)
);

//--- bench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
// ----------------------------------------------------------------
// Self-checking bench for the limit switch output
// ----------------------------------------------------------------
module testbench;
	import lso_pkg::*;
	// A short delay step keeps the timed cases to a few dozen cycles, except the clamped one at about 4000.
	localparam logic [TIMER_WIDTH-1:0] STEPS = 32'h0000_0004;
	localparam lso_func_type FUNCS [4] = '{FUNC_OPEN, FUNC_CLOSED, FUNC_DIAG, FUNC_BLOCK};
	localparam logic [3:0] EXP_FN [2] = '{4'he, 4'h2};
	localparam logic [2:0] EXP_FAIL = 3'h5;
	localparam logic [7:0] EXP_LIM = 8'h66;
	localparam logic [31:0] MEAS [8] = '{32'h1e, 32'hffff_fff1, 32'h05, 32'h19,
		32'h05, 32'h19, 32'h0f, 32'h05};
	int                            errors = 0;
	int                            n_checks = 0;
	logic                          i_core_clk = 1'b0;
	logic                          i_reset_n = 1'b0;
	logic                          i_limit_assigned = 1'b0;
	logic                          i_invert = 1'b0;
	logic                          i_alarm = 1'b0;
	logic                          i_diag_event = 1'b0;
	logic                          i_block_state = 1'b1;
	logic                          o_switch_closed;
	logic                          o_switch_status;
	lso_func_type                  i_function = FUNC_RESET;
	lso_fail_type                  i_failure_mode = FAIL_RESET;
	logic signed [VALUE_WIDTH-1:0] i_on_value = THRESHOLD_RESET;
	logic signed [VALUE_WIDTH-1:0] i_off_value = THRESHOLD_RESET;
	logic signed [VALUE_WIDTH-1:0] i_measured = 32'h0000_0000;
	logic [DELAY_WIDTH-1:0]        i_on_delay = DELAY_RESET;
	logic [DELAY_WIDTH-1:0]        i_off_delay = DELAY_RESET;

	lso_limit_switch #(.STEP_CYCLES(STEPS)) dut_u (
		.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_function(i_function),
		.i_limit_assigned(i_limit_assigned), .i_on_value(i_on_value), .i_off_value(i_off_value),
		.i_on_delay(i_on_delay), .i_off_delay(i_off_delay), .i_failure_mode(i_failure_mode),
		.i_invert(i_invert), .i_measured(i_measured), .i_alarm(i_alarm),
		.i_diag_event(i_diag_event), .i_block_state(i_block_state),
		.o_switch_closed(o_switch_closed), .o_switch_status(o_switch_status)
	);

	// Free-running core clock, 50 ns period.
	initial begin
		forever #25 i_core_clk = ~i_core_clk;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Inputs move on falling edges, so outputs are settled when compared.
	task automatic step(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask

	task automatic expect_out(input string nm, input logic exp);
		`CHK(nm, exp, o_switch_closed)
		`CHK(nm, exp, o_switch_status)
	endtask

	// Bounded wait; a stuck contact ends the run rather than hanging it.
	task automatic wait_out(input logic exp, input int lo, input int hi);
		int n;
		n = 0;
		while (o_switch_closed !== exp && n < hi) begin
			step(1);
			n++;
		end
		`CHK("delay too short", 1'b1, 1'(n >= lo))
		expect_out("delayed state", exp);
		if (n >= hi) begin
			errors++;
			summarize();
		end
	endtask

	initial begin
		step(12);
		i_reset_n = 1'b1;
		step(4);
		expect_out("defaults", 1'b0);
		i_function = FUNC_CLOSED;
		step(4);
		expect_out("closed before alarm", 1'b1);
		i_alarm = 1'b1;
		step(4);
		expect_out("alarm default", 1'b0);
		i_alarm = 1'b0;
		for (int p = 0; p < 2; p++) begin
			i_diag_event = 1'(p);
			i_block_state = ~1'(p);
			for (int k = 0; k < 4; k++) begin
				i_function = FUNCS[k];
				step(4);
				expect_out("function", EXP_FN[p][k]);
			end
		end
		i_function = FUNC_CLOSED;
		i_alarm = 1'b1;
		for (int f = 0; f < 3; f++) begin
			i_failure_mode = lso_fail_type'(f);
			step(4);
			expect_out("failure mode", EXP_FAIL[f]);
		end
		i_failure_mode = lso_fail_type'(2'h3);
		step(4);
		expect_out("unused failure code", 1'b0);
		i_alarm = 1'b0;
		i_failure_mode = FAIL_OPEN;
		i_invert = 1'b1;
		step(4);
		expect_out("invert closed", 1'b0);
		i_function = FUNC_OPEN;
		step(4);
		expect_out("invert open", 1'b1);
		i_invert = 1'b0;
		i_function = lso_func_type'(3'h5);
		step(4);
		expect_out("unused function", 1'b0);
		i_function = FUNC_LIMIT;
		i_on_value = 32'hffff_fff6;
		i_off_value = 32'h0000_0014;
		for (int i = 0; i < 8; i++) begin
			if (i == 5) begin
				i_on_value = 32'h0000_0014;
				i_off_value = 32'h0000_000a;
			end
			i_measured = MEAS[i];
			step(5);
			expect_out("limit", EXP_LIM[i]);
		end
		i_limit_assigned = 1'b1;
		i_on_delay = 10'h002;
		i_off_delay = 10'h003;
		i_measured = 32'h0000_0019;
		wait_out(1'b1, 8, 16);
		i_measured = 32'h0000_0005;
		wait_out(1'b0, 12, 20);
		// A setting above 100.0 s is clamped; without a monitored variable no delay applies.
		i_on_delay = 10'h3ff;
		i_measured = 32'h0000_0019;
		wait_out(1'b1, 4003, 4008);
		i_limit_assigned = 1'b0;
		i_measured = 32'h0000_0005;
		wait_out(1'b0, 3, 5);
		summarize();
	end
endmodule
